/* File: hdl/mtc_params.svh */
`ifndef MTC_PARAMS_SVH
`define MTC_PARAMS_SVH
// default widths of the channel index, the point index and the delay counter
`define MTC_CH_W        4
`define MTC_PT_W        16
`define MTC_DLY_W       16
// delay counter value on which the held trigger is acted upon
`define MTC_DLY_LAST    1
`endif

/* File: hdl/mtc_pkg.sv */
package mtc_pkg;
   // how many triggers are accepted
   typedef enum logic [1:0] {MTC_MODE_CONT, MTC_MODE_SINGLE, MTC_MODE_HOLD} mtc_mode_e;
   // where triggers come from
   typedef enum logic [1:0] {MTC_SRC_INT, MTC_SRC_EXT, MTC_SRC_BUS} mtc_src_e;
endpackage : mtc_pkg

/* File: hdl/mtc_trigger_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mtc_params.svh"

module mtc_trigger_ctrl #(
   parameter int CH_W  = `MTC_CH_W,
   parameter int PT_W  = `MTC_PT_W,
   parameter int DLY_W = `MTC_DLY_W
) (
   // clock and reset
   input  wire  logic                  clk,
   input  wire  logic                  rst,
   // settings
   input  wire  mtc_pkg::mtc_mode_e    init_mode,
   input  wire  mtc_pkg::mtc_src_e     trig_src,
   input  wire  logic                  step_per_point,
   input  wire  logic                  pol_rising,
   input  wire  logic                  wait_before_sample,
   input  wire  logic [DLY_W-1:0]      ext_delay,
   input  wire  logic [CH_W-1:0]       num_chan,
   input  wire  logic [PT_W-1:0]       num_points,
   // program commands, one-cycle pulses
   input  wire  logic                  single_arm,
   input  wire  logic                  bus_trig,
   input  wire  logic                  abort_cmd,
   input  wire  logic                  settings_chg,
   // external trigger pin
   input  wire  logic                  ext_trig_in,
   // measurement engine handshake
   output logic                        setup_go,
   input  wire  logic                  setup_done,
   output logic                        sample_go,
   input  wire  logic                  sample_done,
   output logic [CH_W-1:0]             chan_idx,
   output logic [PT_W-1:0]             point_idx,
   // status
   output logic                        stopped,
   output logic                        waiting,
   output logic                        cycle_done
);
   import mtc_pkg::*;

   typedef enum logic [2:0] {ST_STOP, ST_POINT, ST_WAIT, ST_DLY, ST_SETUP, ST_SAMPLE} mtc_state_e;

   mtc_state_e          state_q, state_d;
   logic                meta_q, sync_q, prev_q;
   logic [DLY_W-1:0]    dly_q;
   logic                pend_q, first_q, arm_q;
   logic [CH_W-1:0]     chan_q;
   logic [PT_W-1:0]     point_q;
   logic                setup_go_q, sample_go_q, stopped_q, waiting_q, cycle_done_q;

   // edge detection against the registered previous sample
   wire rise_w       = sync_q & ~prev_q;
   wire fall_w       = ~sync_q & prev_q;
   wire ext_edge     = pol_rising ? rise_w : fall_w;
   wire ext_sel      = (trig_src == MTC_SRC_EXT);
   wire trig_hit     = (trig_src == MTC_SRC_INT) ||
                       (ext_sel && ext_edge) ||
                       ((trig_src == MTC_SRC_BUS) && bus_trig);
   // gating applies at the first point, and at every point when stepping per point with the external source
   wire gate_here    = first_q | (ext_sel & step_per_point);
   wire gate_samp    = ext_sel & wait_before_sample;
   wire use_dly      = ext_sel && (ext_delay != '0);
   wire dly_end      = (dly_q == DLY_W'(`MTC_DLY_LAST));
   wire last_pt      = (point_q == PT_W'(num_points - 1'b1));
   wire last_ch      = (chan_q == CH_W'(num_chan - 1'b1));
   wire pt_finish    = (state_q == ST_SAMPLE) && sample_done;
   wire cyc_finish   = pt_finish && last_pt && last_ch;
   wire force_stop   = abort_cmd | settings_chg;
   wire start_ok     = (init_mode == MTC_MODE_CONT) |
                       ((init_mode == MTC_MODE_SINGLE) & arm_q);
   wire resume_st    = pend_q;
   wire cycle_start  = (state_q == ST_STOP) && (state_d == ST_POINT);

   // next-state; triggers only count in wait, so a running cycle ignores them
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_STOP:
            if (start_ok && init_mode != MTC_MODE_HOLD) state_d = ST_POINT;
         ST_POINT:
            state_d = (gate_here && !gate_samp) ? ST_WAIT : ST_SETUP;
         ST_WAIT:
            if (init_mode == MTC_MODE_HOLD) state_d = ST_STOP;
            else if (trig_hit)
               state_d = use_dly ? ST_DLY : (resume_st ? ST_SAMPLE : ST_SETUP);
         ST_DLY:
            if (dly_end) state_d = resume_st ? ST_SAMPLE : ST_SETUP;
         ST_SETUP:
            if (setup_done)
               state_d = (gate_here && gate_samp) ? ST_WAIT : ST_SAMPLE;
         ST_SAMPLE:
            if (cyc_finish)
               state_d = (init_mode == MTC_MODE_CONT) ? ST_POINT : ST_STOP;
            else if (sample_done) state_d = ST_POINT;
      endcase
      if (force_stop) state_d = ST_STOP;
   end

   // state register
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst) state_q <= ST_STOP;
      else     state_q <= state_d;
   end

   // two-flop synchroniser plus the previous sample for the edge detector
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         prev_q <= 1'b0;
      end
      else
      begin
         meta_q <= ext_trig_in;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // delay counter loaded on detection, counts down to expiry
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)                                 dly_q <= '0;
      else if (state_q == ST_WAIT && trig_hit) dly_q <= ext_delay;
      else if (state_q == ST_DLY)              dly_q <= dly_q - 1'b1;
   end

   // one-shot arming; a new arm command wins over its consumption
   // a forced stop drops a stale arm so that it cannot fire a later one-shot
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst) arm_q <= 1'b0;
      else     arm_q <= single_arm |
                        (arm_q & ~force_stop & ~(cycle_start & init_mode == MTC_MODE_SINGLE));
   end

   // point flags: first point of a cycle, and whether the wait sits before sampling
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         first_q <= 1'b0;
         pend_q  <= 1'b0;
      end
      else
      begin
         if (cycle_start || (cyc_finish && state_d == ST_POINT)) first_q <= 1'b1;
         else if (pt_finish)                                     first_q <= 1'b0;
         if (state_q == ST_POINT)      pend_q <= 1'b0;
         else if (state_q == ST_SETUP) pend_q <= 1'b1;
      end
   end

   // channel and point indices walk all points of all open channels
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         chan_q  <= '0;
         point_q <= '0;
      end
      else if (cycle_start)
      begin
         chan_q  <= '0;                                                     // rewind kept synchronous
         point_q <= '0;
      end
      else if (pt_finish && !force_stop)
      begin
         point_q <= last_pt ? '0 : point_q + 1'b1;
         chan_q  <= !last_pt ? chan_q : (last_ch ? '0 : chan_q + 1'b1);
      end
   end

   // registered outputs; go pulses mark entry into setup or sampling
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         setup_go_q   <= 1'b0;
         sample_go_q  <= 1'b0;
         stopped_q    <= 1'b1;
         waiting_q    <= 1'b0;
         cycle_done_q <= 1'b0;
      end
      else
      begin
         setup_go_q   <= (state_d == ST_SETUP) && (state_q != ST_SETUP);
         sample_go_q  <= (state_d == ST_SAMPLE) && (state_q != ST_SAMPLE);
         stopped_q    <= (state_d == ST_STOP);
         waiting_q    <= (state_d == ST_WAIT) || (state_d == ST_DLY);
         cycle_done_q <= cyc_finish && !force_stop;
      end
   end

   assign setup_go   = setup_go_q;
   assign sample_go  = sample_go_q;
   assign stopped    = stopped_q;
   assign waiting    = waiting_q;
   assign cycle_done = cycle_done_q;
   assign chan_idx   = chan_q;
   assign point_idx  = point_q;

   // checks
   property p_edge_fall;
      @(posedge clk) disable iff (rst)
      (!pol_rising && sync_q) ##1 (!pol_rising && !sync_q) |-> ext_edge;
   endproperty
   a_edge_fall: assert property (p_edge_fall) else $error("falling edge missed");

   property p_edge_rise;
      @(posedge clk) disable iff (rst)
      (pol_rising && !sync_q) ##1 (pol_rising && sync_q) |-> ext_edge;
   endproperty
   a_edge_rise: assert property (p_edge_rise) else $error("rising edge missed");

   property p_edge_pulse;
      @(posedge clk) disable iff (rst)
      ext_edge |=> !ext_edge;
   endproperty
   a_edge_pulse: assert property (p_edge_pulse) else $error("edge pulse too long");

   property p_hold;
      @(posedge clk) disable iff (rst)
      (stopped_q && init_mode == MTC_MODE_HOLD && !force_stop) |=> stopped_q;
   endproperty
   a_hold: assert property (p_hold) else $error("hold mode left stop");

   property p_abort;
      @(posedge clk) disable iff (rst)
      force_stop |=> stopped_q && !waiting_q && state_q == ST_STOP;
   endproperty
   a_abort: assert property (p_abort) else $error("abort did not stop");

   property p_single_end;
      @(posedge clk) disable iff (rst)
      (cyc_finish && init_mode == MTC_MODE_SINGLE && !force_stop) |=> stopped_q;
   endproperty
   a_single_end: assert property (p_single_end) else $error("single did not stop");

   property p_cont_restart;
      @(posedge clk) disable iff (rst)
      (cyc_finish && init_mode == MTC_MODE_CONT && !force_stop) |=>
         state_q == ST_POINT && first_q;
   endproperty
   a_cont_restart: assert property (p_cont_restart) else $error("cycle not restarted");

   property p_delay;
      @(posedge clk) disable iff (rst)
      (state_q == ST_WAIT && trig_hit && use_dly && ext_delay == DLY_W'(2) && !force_stop)
         |=> state_q == ST_DLY ##1 (state_q == ST_DLY || $past(force_stop));
   endproperty
   a_delay: assert property (p_delay) else $error("delay cut short");

   property p_point_wait;
      @(posedge clk) disable iff (rst)
      (pt_finish && !cyc_finish && ext_sel && step_per_point && !gate_samp
         && !force_stop ##1 !force_stop) |=> state_q == ST_WAIT;
   endproperty
   a_point_wait: assert property (p_point_wait) else $error("per point did not wait");

   property p_setup_first;
      @(posedge clk) disable iff (rst)
      (state_q == ST_SETUP && state_d == ST_SAMPLE) |-> setup_done;
   endproperty
   a_setup_first: assert property (p_setup_first) else $error("sample before setup");

endmodule : mtc_trigger_ctrl

`default_nettype wire

/* File: tb/mtc_ext_src.sv */
`timescale 1ns/10ps
`default_nettype none

module mtc_ext_src (
   // clock
   input  wire logic clk,
   // request from the bench and the polarity to produce
   input  wire logic fire,
   input  wire logic rising,
   // trigger pin towards the controller
   output logic      ext_trig
);
   logic [2:0] hold_q = 3'h0;

   // keep the pulse active four cycles so a two-stage synchroniser cannot miss it
   always_ff @(posedge clk)
      if (fire)
         hold_q <= 3'h4;
      else if (hold_q != 3'h0)
         hold_q <= hold_q - 3'h1;

   // idle at the inactive level; the trailing edge is the wrong polarity on purpose
   assign ext_trig = (hold_q != 3'h0) ? rising : ~rising;
endmodule : mtc_ext_src
`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/10ps
`default_nettype none

module tb;
   import mtc_pkg::*;
   // stimulus
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   mtc_mode_e   mode = MTC_MODE_HOLD;
   mtc_src_e    src = MTC_SRC_INT;
   logic        per_pt = 1'b0, pol = 1'b0, wbs = 1'b0, s_done = 1'b0, m_done = 1'b0;
   logic        arm = 1'b0, btrig = 1'b0, abort = 1'b0, chg = 1'b0, fire = 1'b0;
   logic [15:0] dly = 16'h0000;
   // observed
   wire logic   s_go, m_go, stopped, waiting, cyc_done, ext_pin;
   wire logic [3:0]  ch;
   wire logic [15:0] pt;
   logic [3:0]  exp_ch = 4'h0;
   logic [15:0] exp_pt = 16'h0000;
   int          n_set = 0, n_smp = 0, n_cyc = 0, n_errors = 0, total_checks = 0;

   mtc_trigger_ctrl dut_u (.clk(clk), .rst(rst), .init_mode(mode), .trig_src(src),
      .step_per_point(per_pt), .pol_rising(pol), .wait_before_sample(wbs),
      .ext_delay(dly), .num_chan(4'h2), .num_points(16'h0003), .single_arm(arm),
      .bus_trig(btrig), .abort_cmd(abort), .settings_chg(chg), .ext_trig_in(ext_pin),
      .setup_go(s_go), .setup_done(s_done), .sample_go(m_go), .sample_done(m_done),
      .chan_idx(ch), .point_idx(pt), .stopped(stopped), .waiting(waiting),
      .cycle_done(cyc_done));
   mtc_ext_src src_u (.clk(clk), .fire(fire), .rising(pol), .ext_trig(ext_pin));

   always #10 clk = ~clk;

   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   task automatic check(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1)
      begin
         n_errors++;
         $display("ERROR at %0t: %s", $time, msg);
      end
   endtask : check

   // engine answers every go pulse one cycle later, which also stretches each point
   always @(posedge clk)
   begin
      s_done <= s_go;
      m_done <= m_go;
      // a stop rewinds the expected position, since the next cycle starts afresh
      if (stopped === 1'b1)
      begin
         exp_ch <= 4'h0;
         exp_pt <= 16'h0000;
      end
      if (s_go === 1'b1)
      begin
         n_set  <= n_set + 1;
         check(ch === exp_ch && pt === exp_pt, "point out of order");
         exp_pt <= (pt == 16'h0002) ? 16'h0000 : pt + 16'h0001;
         exp_ch <= (pt != 16'h0002) ? ch : ((ch == 4'h1) ? 4'h0 : ch + 4'h1);
      end
      if (m_go === 1'b1)
      begin
         n_smp <= n_smp + 1;
         check(n_set > n_smp, "sampling without setup");
      end
      if (cyc_done === 1'b1)
         n_cyc <= n_cyc + 1;
   end

   // one-cycle command pulse: 0 fire, 1 arm, 2 bus trigger, 3 abort
   task automatic kick(input int k);
      @(posedge clk);
      {abort, btrig, arm, fire} <= 4'h1 << k;
      @(posedge clk);
      {abort, btrig, arm, fire} <= 4'h0;
   endtask : kick

   // settings change always pulses chg, as the controller must restart from stop
   task automatic cfg(input mtc_mode_e m, input mtc_src_e s, input logic p, input logic w);
      @(posedge clk);
      mode   <= m;
      src    <= s;
      per_pt <= p;
      wbs    <= w;
      chg    <= 1'b1;
      @(posedge clk);
      chg    <= 1'b0;
   endtask : cfg

   // bounded wait for a number of finished cycles; a miss ends the run
   task automatic wait_cyc(input int tgt);
      for (int i = 0; i < 600 && n_cyc < tgt; i++) @(posedge clk);
      check(n_cyc >= tgt, "cycle never finished");
      if (n_cyc < tgt)
         end_of_test();
   endtask : wait_cyc

   // cycles from an external pulse to the next go pulse of either phase
   task automatic lat(output int l);
      int b;
      b = n_set + n_smp;
      kick(0);
      for (l = 2; l < 200 && n_set + n_smp == b; l++) @(posedge clk);
      check(l < 200, "no response to trigger");
      if (l >= 200)
         end_of_test();
   endtask : lat

   task automatic t_cont;
      int c0, s0;
      cfg(MTC_MODE_CONT, MTC_SRC_INT, 1'b0, 1'b0);
      c0 = n_cyc;
      s0 = n_smp;
      wait_cyc(c0 + 3);
      check(n_smp - s0 == 18, "points per cycle");
   endtask : t_cont

   task automatic t_hold;
      int b;
      cfg(MTC_MODE_HOLD, MTC_SRC_INT, 1'b0, 1'b0);
      repeat (3) @(posedge clk);
      b = n_set;
      kick(2);
      repeat (40) @(posedge clk);
      check(stopped === 1'b1 && n_set == b, "hold not stopped");
   endtask : t_hold

   task automatic t_single;
      int b, c0;
      cfg(MTC_MODE_SINGLE, MTC_SRC_BUS, 1'b0, 1'b0);
      c0 = n_cyc;
      b = n_set;
      kick(1);
      repeat (20) @(posedge clk);
      check(waiting === 1'b1 && n_set == b, "bus source started alone");
      kick(2);
      wait_cyc(c0 + 1);
      repeat (3) @(posedge clk);
      b = n_set;
      kick(2);
      repeat (30) @(posedge clk);
      check(stopped === 1'b1 && n_set == b, "one-shot ran again");
   endtask : t_single

   task automatic t_ext(input logic p, input logic w, input logic [15:0] d);
      int l0, l1, c0, s0, g0;
      cfg(MTC_MODE_HOLD, MTC_SRC_EXT, 1'b0, w);
      pol <= p;
      dly <= 16'h0000;
      repeat (8) @(posedge clk);
      cfg(MTC_MODE_CONT, MTC_SRC_EXT, 1'b0, w);
      c0 = n_cyc;
      s0 = n_smp;
      g0 = n_set;
      repeat (12) @(posedge clk);
      check(n_set - g0 == int'(w) && n_smp == s0, "ran before trigger");
      lat(l0);
      check(l0 < 9, "wrong trigger edge");
      kick(0);
      wait_cyc(c0 + 1);
      check(n_smp - s0 == 6, "sweep not whole");
      repeat (30) @(posedge clk);
      check(n_cyc == c0 + 1 && n_smp - s0 == 6 && waiting === 1'b1, "late trigger taken");
      dly <= d;
      lat(l1);
      check(l1 - l0 == int'(d), "delay off");
      wait_cyc(c0 + 2);
   endtask : t_ext

   // per-point stepping with the wait before sampling (w=1) or before setup (w=0)
   task automatic t_point(input logic w);
      int s0, g0;
      cfg(MTC_MODE_HOLD, MTC_SRC_EXT, 1'b1, w);
      dly <= 16'h0000;
      cfg(MTC_MODE_CONT, MTC_SRC_EXT, 1'b1, w);
      s0 = n_smp;
      g0 = n_set;
      repeat (12) @(posedge clk);
      check(n_set - g0 == int'(w) && n_smp == s0, "wait in wrong place");
      for (int i = 1; i <= 2; i++)
      begin
         kick(0);
         repeat (25) @(posedge clk);
         check(n_smp - s0 == i && n_set - g0 == i + int'(w), "one point per edge");
      end
      kick(3);
      repeat (25) @(posedge clk);
      check(pt === 16'h0000 && ch === 4'h0, "abort kept position");
   endtask : t_point

   // main sequence
   initial
   begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_cont();
      t_hold();
      t_single();
      t_ext(1'b0, 1'b0, 16'h0005);
      t_ext(1'b1, 1'b1, 16'h0002);
      t_point(1'b1);
      t_point(1'b0);
      end_of_test();
   end
endmodule : tb
`default_nettype wire
